// file: design/tciws_sequencer.sv
// Idle, transport selection and write sequencer of a two-unit tape controller
//
// The address map and strobed register access were decided locally.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Idle keeps status, requests function when on-line
// - Strobe latches word, clears status unless 02
// - Select transport from bits 17-18 and switch
// - Bad address sets illegal instruction
// - Missing density sets illegal instruction
// - No acknowledge or ready sets fault
// - Write to locked reel sets fault, lockout
// - Reverse at load point sets illegal operation
// - Rewinding transport clears normal completion
// - Rewind unconfirmed in window clears completion
// - Abandon on error, interrupt if enabled
// - Write starts request, motion, timing together
// - Start delay from load point or gap
// - First word late sets timing error
// - Prefetch words, write five frames each
// - No data: trail, write reset, head spacing
// - Normal completion requests repeat for 300us
// - No repeat: wait 16us, stop, go idle
// - Repeat strobe continues without stopping tape
// - End-of-tape runs ten inches then terminates
// - Disabled interrupt is held pending, except on chained repeat
// - Chained repeat interrupts only when enabled
// - Failed instruction: no request, interrupt after window
module tciws_sequencer #(
  parameter int LOADPT_CYC = tciws_pkg::LOADPT_CYC,
  parameter int GAP_CYC    = tciws_pkg::GAP_CYC,
  parameter int XGAP_CYC   = tciws_pkg::XGAP_CYC,
  parameter int HEADSP_CYC = tciws_pkg::HEADSP_CYC,
  parameter int EOT_CYC    = tciws_pkg::EOT_CYC,
  parameter int REP_CYC    = tciws_pkg::REP_CYC,
  parameter int STOP_CYC   = tciws_pkg::STOP_CYC
) (
  // Clock and reset
  input  wire logic                            i_sys_clk,
  input  wire logic                            i_sys_rst,
  // Maintenance panel
  input  wire logic                            i_online,
  input  wire logic                            i_addr_swap,
  // Host channel
  output logic                                 o_function_request_out,
  input  wire logic                            i_function_strobe_in,
  input  wire logic [tciws_pkg::WORD_W-1:0]    i_out_word,
  output logic                                 o_out_req,
  input  wire logic                            i_out_ack,
  output logic                                 o_int,
  input  wire logic                            i_int_ack,
  input  wire logic                            i_int_en,
  output logic [tciws_pkg::WORD_W-1:0]         o_in_data,
  output logic [tciws_pkg::ST_W-1:0]           o_status,
  // Tape transports
  output logic [1:0]                           o_tt_sel,
  input  wire logic [1:0]                      i_tt_sel_ack,
  input  wire logic [1:0]                      i_tt_ready,
  input  wire logic [1:0]                      i_tt_loadpt,
  input  wire logic [1:0]                      i_tt_wlock,
  input  wire logic [1:0]                      i_tt_rewinding,
  input  wire logic [1:0]                      i_tt_eot,
  input  wire logic                            i_tt_par_err,
  output logic                                 o_tt_fwd,
  output logic                                 o_tt_write,
  output logic                                 o_tt_read,
  output logic                                 o_tt_write_reset,
  output logic                                 o_tt_rewind,
  output logic [2:0]                           o_tt_density,
  output logic [tciws_pkg::CHAR_W:0]           o_tt_data,
  output logic                                 o_tt_strobe
);
  localparam int W  = tciws_pkg::WORD_W;
  localparam int TW = tciws_pkg::TMR_W;

  if (LOADPT_CYC < 1 || GAP_CYC < 1 || XGAP_CYC < 1 || HEADSP_CYC < 1 ||
      EOT_CYC < 1 || REP_CYC < 1 || STOP_CYC < 1 || EOT_CYC >= (1 << TW) ||
      LOADPT_CYC >= (1 << TW) || XGAP_CYC >= (1 << TW) || STOP_CYC >= (1 << TW) ||
      GAP_CYC >= (1 << TW) || HEADSP_CYC >= (1 << TW) || REP_CYC >= (1 << TW))
  begin : g_bad
    $error("tciws_sequencer: timing parameter out of range");
  end

  typedef struct packed {
    tciws_pkg::tciws_state_t     st;
    logic [W-1:0]                instr;
    logic [tciws_pkg::ST_W-1:0]  status;
    logic [1:0]                  sel;
    logic                        sel_ok;
    logic [W-1:0]                buf0;
    logic [W-1:0]                buf1;
    logic [1:0]                  nbuf;
    logic [W-1:0]                shreg;
    logic [2:0]                  nchar;
    logic [TW-1:0]               tmr;
    logic [11:0]                 ctmr;
    logic [TW-1:0]               eot_tmr;
    logic                        eot_seen;
    logic                        irq;
    logic                        pend;
    logic [W-1:0]                indata;
    logic [tciws_pkg::CHAR_W:0]  tdata;
    logic                        tstrobe;
    logic                        wreset;
    logic                        rwcmd;
    logic                        fwd;
    logic                        wr;
    logic                        rd;
  } tciws_regs_t;

  tciws_regs_t r_q;
  tciws_regs_t r_d;

  function automatic logic [11:0] char_cyc(input logic [1:0] dens);
    unique case (dens)
      tciws_pkg::DENS_800: char_cyc = 12'(tciws_pkg::CHAR_CYC_800);
      tciws_pkg::DENS_556: char_cyc = 12'(tciws_pkg::CHAR_CYC_556);
      default:             char_cyc = 12'(tciws_pkg::CHAR_CYC_200);
    endcase
  endfunction

  function automatic tciws_regs_t raise_int(input tciws_regs_t r, input logic en);
    raise_int = r;
    if (en)
    begin
      raise_int.irq    = 1'b1;
      raise_int.indata = {{(W - tciws_pkg::ST_W){1'b0}}, r.status};
    end
    else
      raise_int.pend = 1'b1;
  endfunction

  // Bad density or unknown code on an instruction needing one
  function automatic logic bad_code(input logic [5:0] fc, input logic [1:0] dens);
    logic known;
    known = fc == tciws_pkg::FC_WRITE || fc == tciws_pkg::FC_WR_XG ||
            fc == tciws_pkg::FC_RD_FWD || fc == tciws_pkg::FC_RD_REV;
    bad_code = !known || dens == tciws_pkg::DENS_NONE;
  endfunction

  always_comb
  begin
    logic [5:0] fc;
    logic [1:0] dens;
    logic       sidx;
    logic       is_wr;
    logic       nodens;
    logic       needs;
    logic       pop;
    logic       push;
    logic [1:0] a;
    fc     = r_q.instr[tciws_pkg::FC_LSB +: 6];
    dens   = r_q.instr[tciws_pkg::DENS_LSB +: 2];
    sidx   = r_q.sel[1];
    is_wr  = fc == tciws_pkg::FC_WRITE || fc == tciws_pkg::FC_WR_XG;
    nodens = fc == tciws_pkg::FC_REWIND || fc == tciws_pkg::FC_STATUS ||
             fc == tciws_pkg::FC_MCLR || fc == tciws_pkg::FC_LOOP;
    needs  = fc != tciws_pkg::FC_MCLR && fc != tciws_pkg::FC_LOOP;
    pop    = 1'b0;
    push   = o_out_req && i_out_ack;
    a      = i_out_word[tciws_pkg::ADDR_LSB +: 2];
    r_d    = r_q;
    r_d.tstrobe = 1'b0;
    r_d.wreset  = 1'b0;
    r_d.rwcmd   = 1'b0;
    if (r_q.tmr != '0)
      r_d.tmr = r_q.tmr - TW'(1);
    if (r_q.eot_seen && r_q.eot_tmr != '0)
      r_d.eot_tmr = r_q.eot_tmr - TW'(1);
    // Ack clears first so a new interrupt in the same cycle wins
    if (i_int_ack)
      r_d.irq = 1'b0;
    if (r_q.pend && i_int_en && !r_q.irq)
    begin
      r_d.pend = 1'b0;
      r_d = raise_int(r_d, 1'b1);
    end
    unique case (r_q.st)
      tciws_pkg::S_IDLE:
      begin
        r_d.eot_seen = 1'b0;
        r_d.nbuf     = 2'h0;
        if (i_online && i_function_strobe_in)
        begin
          r_d.instr = i_out_word;
          if (i_out_word[tciws_pkg::FC_LSB +: 6] != tciws_pkg::FC_STATUS)
          begin
            r_d.status = '0;
            r_d.status[tciws_pkg::ST_NORMAL] = 1'b1;
          end
          r_d.sel_ok = a[0] ^ a[1];
          r_d.sel    = i_addr_swap ? {a[0], a[1]} : a;
          r_d.tmr    = TW'(tciws_pkg::SEL_CYC - 1);
          r_d.st     = tciws_pkg::S_SEL;
        end
      end
      tciws_pkg::S_SEL:
        if (r_q.tmr == '0)
          r_d.st = tciws_pkg::S_CHECK;
      tciws_pkg::S_CHECK:
      begin
        r_d.status[tciws_pkg::ST_LOADPT] = i_tt_loadpt[sidx];
        r_d.status[tciws_pkg::ST_READY]  = i_tt_ready[sidx];
        r_d.status[tciws_pkg::ST_REWIND] = i_tt_rewinding[sidx];
        if (fc != tciws_pkg::FC_STATUS)
        begin
          if (needs && !r_q.sel_ok)
            r_d.status[tciws_pkg::ST_ILL_IN] = 1'b1;
          if (!nodens && bad_code(fc, dens))
            r_d.status[tciws_pkg::ST_ILL_IN] = 1'b1;
          if (needs && r_q.sel_ok && !(i_tt_sel_ack[sidx] && i_tt_ready[sidx]))
            r_d.status[tciws_pkg::ST_FAULT] = 1'b1;
          if (is_wr && i_tt_wlock[sidx])
          begin
            r_d.status[tciws_pkg::ST_FAULT] = 1'b1;
            r_d.status[tciws_pkg::ST_WLOCK] = 1'b1;
          end
          if (fc == tciws_pkg::FC_RD_REV && i_tt_loadpt[sidx])
            r_d.status[tciws_pkg::ST_ILL_OP] = 1'b1;
          if (r_d.status[tciws_pkg::ST_ILL_IN +: 4] != 4'h0)
            r_d.status[tciws_pkg::ST_NORMAL] = 1'b0;
          if (fc != tciws_pkg::FC_REWIND && i_tt_rewinding[sidx])
            r_d.status[tciws_pkg::ST_NORMAL] = 1'b0;
        end
        if (!r_d.status[tciws_pkg::ST_NORMAL] || !(is_wr || fc == tciws_pkg::FC_REWIND))
          r_d.st = tciws_pkg::S_FIN;
        else if (fc == tciws_pkg::FC_REWIND)
        begin
          r_d.rwcmd = 1'b1;
          r_d.tmr   = TW'(tciws_pkg::RWD_CYC - 1);
          r_d.st    = tciws_pkg::S_RWD;
        end
        else
        begin
          r_d.fwd = 1'b1;
          r_d.wr  = 1'b1;
          r_d.rd  = 1'b1;
          r_d.st  = tciws_pkg::S_WSTART;
          if (i_tt_loadpt[sidx])
            r_d.tmr = TW'(LOADPT_CYC - 1);
          else
            r_d.tmr = (fc == tciws_pkg::FC_WR_XG) ? TW'(XGAP_CYC - 1) : TW'(GAP_CYC - 1);
        end
      end
      tciws_pkg::S_RWD:
      begin
        if (i_tt_rewinding[sidx])
          r_d.st = tciws_pkg::S_FIN;
        else if (r_q.tmr == '0)
        begin
          r_d.status[tciws_pkg::ST_NORMAL] = 1'b0;
          r_d.st = tciws_pkg::S_FIN;
        end
      end
      tciws_pkg::S_FIN:
      begin
        r_d    = raise_int(r_d, i_int_en);
        r_d.st = tciws_pkg::S_IDLE;
      end
      tciws_pkg::S_WSTART:
        if (r_q.tmr == '0)
        begin
          if (r_q.nbuf == 2'h0)
          begin
            r_d.status[tciws_pkg::ST_TIMING] = 1'b1;
            r_d.status[tciws_pkg::ST_NORMAL] = 1'b0;
            r_d.tmr = TW'(REP_CYC - 1);
            r_d.st  = tciws_pkg::S_REPEAT;
          end
          else
          begin
            pop       = 1'b1;
            r_d.shreg = r_q.buf0;
            r_d.nchar = 3'h0;
            r_d.ctmr  = char_cyc(dens) - 12'h1;
            r_d.st    = tciws_pkg::S_WDATA;
          end
        end
      tciws_pkg::S_WDATA:
        if (r_q.eot_seen && r_q.eot_tmr == '0)
        begin
          r_d.tmr = TW'(tciws_pkg::TRAIL_CHARS) * TW'(char_cyc(dens));
          r_d.st  = tciws_pkg::S_TRAIL;
        end
        else if (r_q.ctmr != 12'h0)
          r_d.ctmr = r_q.ctmr - 12'h1;
        else
        begin
          r_d.tdata   = {^r_q.shreg[W-1 -: tciws_pkg::CHAR_W] ^ r_q.instr[tciws_pkg::PAR_BIT],
                         r_q.shreg[W-1 -: tciws_pkg::CHAR_W]};
          r_d.tstrobe = 1'b1;
          r_d.shreg   = r_q.shreg << tciws_pkg::CHAR_W;
          r_d.nchar   = r_q.nchar + 3'h1;
          r_d.ctmr    = char_cyc(dens) - 12'h1;
          if (r_q.nchar == 3'(tciws_pkg::NCHAR - 1))
          begin
            if (r_q.nbuf != 2'h0)
            begin
              pop       = 1'b1;
              r_d.shreg = r_q.buf0;
              r_d.nchar = 3'h0;
            end
            else
            begin
              r_d.tmr = TW'(tciws_pkg::TRAIL_CHARS) * TW'(char_cyc(dens));
              r_d.st  = tciws_pkg::S_TRAIL;
            end
          end
        end
      tciws_pkg::S_TRAIL:
        if (r_q.tmr == '0)
        begin
          r_d.wreset = 1'b1;
          r_d.tmr    = TW'(HEADSP_CYC - 1);
          r_d.st     = tciws_pkg::S_HEADSP;
        end
      tciws_pkg::S_HEADSP:
        if (r_q.tmr == '0)
        begin
          // normal only without parity or end-of-tape
          if (i_tt_par_err)
            r_d.status[tciws_pkg::ST_PARITY] = 1'b1;
          if (i_tt_par_err || r_q.eot_seen)
            r_d.status[tciws_pkg::ST_NORMAL] = 1'b0;
          r_d.tmr = TW'(REP_CYC - 1);
          r_d.st  = tciws_pkg::S_REPEAT;
        end
      tciws_pkg::S_REPEAT:
      begin
        if (o_function_request_out && i_function_strobe_in)
        begin
          r_d.instr = i_out_word;
          r_d.status[tciws_pkg::ST_CONT] = 1'b1;
        end
        if (r_q.tmr == '0)
        begin
          if (!r_q.status[tciws_pkg::ST_NORMAL])
          begin
            r_d    = raise_int(r_d, i_int_en);
            r_d.tmr = TW'(STOP_CYC - 1);
            r_d.st = tciws_pkg::S_STOP;
          end
          else if (r_d.status[tciws_pkg::ST_CONT])
          begin
            if (i_int_en)
              r_d = raise_int(r_d, 1'b1);
            r_d.st = tciws_pkg::S_CHAIN;
          end
          else
          begin
            r_d.tmr = TW'(tciws_pkg::LATE_CYC - 1);
            r_d.st  = tciws_pkg::S_LATE;
          end
        end
      end
      tciws_pkg::S_LATE:
        if (i_function_strobe_in)
        begin
          r_d.instr = i_out_word;
          r_d.status[tciws_pkg::ST_CONT] = 1'b1;
          r_d    = raise_int(r_d, i_int_en);
          r_d.st = tciws_pkg::S_CHAIN;
        end
        else if (r_q.tmr == '0)
        begin
          r_d    = raise_int(r_d, i_int_en);
          r_d.tmr = TW'(STOP_CYC - 1);
          r_d.st = tciws_pkg::S_STOP;
        end
      tciws_pkg::S_CHAIN:
      begin
        // new density and parity, gap without stopping
        r_d.status = '0;
        r_d.status[tciws_pkg::ST_CONT] = 1'b1;
        if (!is_wr || dens == tciws_pkg::DENS_NONE || r_q.eot_seen)
        begin
          r_d.status[tciws_pkg::ST_ILL_IN] = !r_q.eot_seen;
          r_d.status[tciws_pkg::ST_EOT]    = r_q.eot_seen;
          r_d    = raise_int(r_d, i_int_en);
          r_d.tmr = TW'(STOP_CYC - 1);
          r_d.st = tciws_pkg::S_STOP;
        end
        else
        begin
          r_d.status[tciws_pkg::ST_NORMAL] = 1'b1;
          r_d.tmr = (fc == tciws_pkg::FC_WR_XG) ? TW'(XGAP_CYC - 1) : TW'(GAP_CYC - 1);
          r_d.st  = tciws_pkg::S_WSTART;
        end
      end
      tciws_pkg::S_STOP:
      begin
        // forward and read end first, write last
        r_d.fwd = 1'b0;
        r_d.rd  = 1'b0;
        if (r_q.tmr == '0 && !r_q.irq)
        begin
          r_d.wr = 1'b0;
          r_d.st = tciws_pkg::S_IDLE;
        end
      end
      default:
        r_d.st = tciws_pkg::S_IDLE;
    endcase
    if ((r_q.st == tciws_pkg::S_WSTART || r_q.st == tciws_pkg::S_WDATA) &&
        i_tt_eot[sidx] && !r_q.eot_seen)
    begin
      r_d.eot_seen = 1'b1;
      r_d.eot_tmr  = TW'(EOT_CYC - 1);
      r_d.status[tciws_pkg::ST_EOT] = 1'b1;
    end
    if (pop)
    begin
      r_d.buf0 = r_q.buf1;
      r_d.nbuf = r_q.nbuf - 2'h1;
    end
    if (push)
    begin
      if (r_d.nbuf == 2'h0)
        r_d.buf0 = i_out_word;
      else
        r_d.buf1 = i_out_word;
      r_d.nbuf = r_d.nbuf + 2'h1;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
      r_q <= '0;
    else
      r_q <= r_d;
  end

  // request while idle and on-line, or in the repeat window after normal completion
  assign o_function_request_out = (r_q.st == tciws_pkg::S_IDLE && i_online) ||
                                  (r_q.st == tciws_pkg::S_REPEAT && r_q.status[tciws_pkg::ST_NORMAL]);
  // request while a prefetch slot is free
  assign o_out_req = (r_q.st == tciws_pkg::S_WSTART || r_q.st == tciws_pkg::S_WDATA) &&
                     r_q.nbuf != 2'h2;
  assign o_int            = r_q.irq;
  assign o_in_data        = r_q.indata;
  assign o_status         = r_q.status;
  assign o_tt_sel         = (r_q.st != tciws_pkg::S_IDLE && r_q.sel_ok) ? r_q.sel : 2'h0;
  assign o_tt_fwd         = r_q.fwd;
  assign o_tt_write       = r_q.wr;
  assign o_tt_read        = r_q.rd;
  assign o_tt_write_reset = r_q.wreset;
  assign o_tt_rewind      = r_q.rwcmd;
  assign o_tt_data        = r_q.tdata;
  assign o_tt_strobe      = r_q.tstrobe;
  // Density lines only while an instruction is active
  assign o_tt_density     = (r_q.st == tciws_pkg::S_IDLE) ? 3'h0 :
                            {r_q.instr[tciws_pkg::DENS_LSB +: 2] == tciws_pkg::DENS_200,
                             r_q.instr[tciws_pkg::DENS_LSB +: 2] == tciws_pkg::DENS_556,
                             r_q.instr[tciws_pkg::DENS_LSB +: 2] == tciws_pkg::DENS_800};
endmodule
`default_nettype wire

// file: design/tciws_pkg.sv
// Constants and types for the tape idle and write sequencer
package tciws_pkg;
  // Word and frame layout
  localparam int WORD_W    = 30;
  localparam int CHAR_W    = 6;
  localparam int NCHAR     = 5;
  localparam int FC_LSB    = 24;
  localparam int ADDR_LSB  = 17;
  localparam int DENS_LSB  = 20;
  localparam int PAR_BIT   = 22;
  // Function codes
  localparam logic [5:0] FC_MCLR   = 6'h01;
  localparam logic [5:0] FC_STATUS = 6'h02;
  localparam logic [5:0] FC_REWIND = 6'h04;
  localparam logic [5:0] FC_LOOP   = 6'h08;
  localparam logic [5:0] FC_WRITE  = 6'h10;
  localparam logic [5:0] FC_WR_XG  = 6'h11;
  localparam logic [5:0] FC_RD_FWD = 6'h20;
  localparam logic [5:0] FC_RD_REV = 6'h21;
  // Density field codes
  localparam logic [1:0] DENS_NONE = 2'h0;
  localparam logic [1:0] DENS_800  = 2'h1;
  localparam logic [1:0] DENS_556  = 2'h2;
  localparam logic [1:0] DENS_200  = 2'h3;
  // Status bit positions
  localparam int ST_NORMAL = 0;
  localparam int ST_ILL_IN = 1;
  localparam int ST_FAULT  = 2;
  localparam int ST_WLOCK  = 3;
  localparam int ST_ILL_OP = 4;
  localparam int ST_TIMING = 5;
  localparam int ST_CONT   = 6;
  localparam int ST_EOT    = 7;
  localparam int ST_PARITY = 8;
  localparam int ST_LOADPT = 9;
  localparam int ST_READY  = 10;
  localparam int ST_REWIND = 11;
  localparam int ST_W      = 12;
  // Time base
  localparam int CLK_HZ       = 40_000_000;
  localparam int CLK_MHZ      = CLK_HZ / 1_000_000;
  localparam int TAPE_IPS     = 75;
  localparam int INCH_CYC     = CLK_HZ / TAPE_IPS;
  localparam int CHAR_CYC_800 = CLK_HZ / (800 * TAPE_IPS);
  localparam int CHAR_CYC_556 = INCH_CYC * 10 / 5555;
  localparam int CHAR_CYC_200 = CLK_HZ / (200 * TAPE_IPS);
  localparam int TMR_W        = 24;
  // Distances and times
  localparam int LOADPT_TENTH_IN = 35;
  localparam int LOADPT_CYC      = INCH_CYC * LOADPT_TENTH_IN / 10;
  localparam int GAP_HUND_IN     = 75;
  localparam int GAP_CYC         = INCH_CYC * GAP_HUND_IN / 100;
  localparam int XGAP_HUND_IN    = 300;
  localparam int XGAP_CYC        = INCH_CYC * XGAP_HUND_IN / 100;
  localparam int HEADSP_HUND_IN  = 30;
  localparam int HEADSP_CYC      = INCH_CYC * HEADSP_HUND_IN / 100;
  localparam int EOT_IN          = 10;
  localparam int EOT_CYC         = INCH_CYC * EOT_IN;
  localparam int REP_US          = 300;
  localparam int REP_CYC         = REP_US * CLK_MHZ;
  localparam int LATE_US         = 16;
  localparam int LATE_CYC        = LATE_US * CLK_MHZ;
  localparam int RWD_MAX_US      = 10;
  localparam int RWD_CYC         = RWD_MAX_US * CLK_MHZ;
  localparam int STOP_US         = 5000;
  localparam int STOP_CYC        = STOP_US * CLK_MHZ;
  localparam int TRAIL_CHARS     = 3;
  localparam int SEL_CYC         = 4;
  // Sequencer states
  typedef enum logic [3:0] {
    S_IDLE   = 4'h0,
    S_SEL    = 4'h1,
    S_CHECK  = 4'h2,
    S_RWD    = 4'h3,
    S_FIN    = 4'h4,
    S_WSTART = 4'h5,
    S_WDATA  = 4'h6,
    S_TRAIL  = 4'h7,
    S_HEADSP = 4'h8,
    S_REPEAT = 4'h9,
    S_LATE   = 4'ha,
    S_CHAIN  = 4'hb,
    S_STOP   = 4'hc
  } tciws_state_t;
endpackage

// file: test/tciws_monitor.sv
// Port checker for the tape idle and write sequencer
`timescale 1ns/10ps
`default_nettype none
module tciws_monitor (
  input wire logic                          i_sys_clk,
  input wire logic                          i_sys_rst,
  input wire logic                          i_int_en,
  input wire logic                          o_function_request_out,
  input wire logic                          o_out_req,
  input wire logic                          o_int,
  input wire logic [tciws_pkg::ST_W-1:0]    o_status,
  input wire logic [1:0]                    o_tt_sel,
  input wire logic                          o_tt_fwd,
  input wire logic                          o_tt_write,
  input wire logic                          o_tt_read,
  input wire logic                          o_tt_write_reset,
  input wire logic                          o_tt_strobe
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  property p_req_idle; o_function_request_out |-> !o_out_req; endproperty
  a_req_idle: assert property (p_req_idle) else $error("data request beside function request");
  property p_sel_one; |o_tt_sel |-> $onehot(o_tt_sel); endproperty
  a_sel_one: assert property (p_sel_one) else $error("more than one transport selected");
  property p_start; $rose(o_tt_fwd) |-> o_tt_write && o_tt_read && o_out_req; endproperty
  a_start: assert property (p_start) else $error("write start not simultaneous");
  property p_no_move; o_tt_fwd |-> !(o_status[1] || o_status[3] || o_status[4]); endproperty
  a_no_move: assert property (p_no_move) else $error("motion after rejected instruction");
  property p_frame; o_tt_strobe |-> o_tt_fwd && o_tt_write; endproperty
  a_frame: assert property (p_frame) else $error("frame outside write motion");
  property p_wreset; o_tt_write_reset |-> o_tt_write && !o_tt_strobe ##1 !o_tt_write_reset; endproperty
  a_wreset: assert property (p_wreset) else $error("write reset misplaced");
  property p_repeat; $rose(o_function_request_out) && o_tt_fwd |-> o_status[0]; endproperty
  a_repeat: assert property (p_repeat) else $error("repeat request without normal completion");
  property p_stop; $fell(o_tt_fwd) |-> !o_tt_read && o_tt_write; endproperty
  a_stop: assert property (p_stop) else $error("stop order wrong");
  property p_int_en; $rose(o_int) |-> $past(i_int_en); endproperty
  a_int_en: assert property (p_int_en) else $error("interrupt while disabled");
  c_write: cover property ($rose(o_tt_fwd));
  c_wreset: cover property (o_tt_write_reset);
  c_int: cover property ($rose(o_int));
endmodule
bind tciws_sequencer tciws_monitor tciws_monitor_inst (.*);
`default_nettype wire

// file: test/tciws_tt_model.sv
// Behavioural pair of tape transports
`timescale 1ns/10ps
`default_nettype none
module tciws_tt_model (
  input  wire logic       i_sys_clk,
  input  wire logic [1:0] i_sel,
  input  wire logic [1:0] i_ready_cfg,
  input  wire logic [1:0] i_wlock_cfg,
  input  wire logic [1:0] i_loadpt_cfg,
  output logic [1:0]      o_sel_ack,
  output logic [1:0]      o_ready,
  output logic [1:0]      o_loadpt,
  output logic [1:0]      o_wlock
);
  // Acknowledge lags select, as over a cable
  always @(posedge i_sys_clk)
    o_sel_ack <= i_sel;
  assign o_ready = i_ready_cfg;
  assign o_loadpt = i_loadpt_cfg;
  assign o_wlock = i_wlock_cfg;
endmodule
`default_nettype wire

// file: test/tb_top.sv
// Self-checking bench for the tape idle and write sequencer
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk = 1'b0, rst = 1'b1, en = 1'b0, fs = 1'b0, ack = 1'b0, iack = 1'b0;
  logic [29:0] w = 30'h0, ind, d;
  logic [1:0] rc = 2'h3, wc = 2'h0, lc = 2'h0, sel, sack, rdy, lp, wl;
  logic function_request_out, oreq, oint, stb, sw = 1'b0, pe = 1'b0, fwd, wrt, rd, wrst, rwd;
  logic [2:0] dns;
  logic [11:0] st;
  logic [6:0] fd, np = 7'h0;
  logic [6:0] fq[$];
  logic [4:0] sq[$];
  int errors = 0, num_checks = 0;
  logic [20:0] tbl [8] = '{{6'h10, 2'h0, 2'h1, 2'h3, 2'h0, 2'h0, 5'h02}, {6'h10, 2'h1, 2'h3, 2'h3, 2'h0, 2'h0, 5'h02},
    {6'h10, 2'h1, 2'h2, 2'h1, 2'h0, 2'h0, 5'h04}, {6'h10, 2'h1, 2'h1, 2'h3, 2'h1, 2'h0, 5'h0c},
    {6'h21, 2'h1, 2'h1, 2'h3, 2'h0, 2'h1, 5'h10}, {6'h11, 2'h0, 2'h1, 2'h3, 2'h0, 2'h0, 5'h02},
    {6'h10, 2'h1, 2'h1, 2'h1, 2'h0, 2'h0, 5'h04}, {6'h04, 2'h0, 2'h1, 2'h3, 2'h0, 2'h0, 5'h00}};
  always #12.5 clk = ~clk;
  tciws_sequencer #(.LOADPT_CYC(50), .GAP_CYC(40), .XGAP_CYC(80), .HEADSP_CYC(20), .EOT_CYC(300), .REP_CYC(100),
    .STOP_CYC(30)) tciws_sequencer_inst (.i_sys_clk(clk), .i_sys_rst(rst), .i_online(1'b1), .i_addr_swap(sw),
    .o_function_request_out(function_request_out), .i_function_strobe_in(fs), .i_out_word(w), .o_out_req(oreq), .i_out_ack(ack),
    .o_int(oint), .i_int_ack(iack), .i_int_en(en), .o_in_data(ind), .o_status(st), .o_tt_sel(sel),
    .i_tt_sel_ack(sack), .i_tt_ready(rdy), .i_tt_loadpt(lp), .i_tt_wlock(wl), .i_tt_rewinding(2'h0),
    .i_tt_eot(2'h0), .i_tt_par_err(pe), .o_tt_fwd(fwd), .o_tt_write(wrt), .o_tt_read(rd), .o_tt_write_reset(wrst),
    .o_tt_rewind(rwd), .o_tt_density(dns), .o_tt_data(fd), .o_tt_strobe(stb));
  tciws_tt_model tciws_tt_model_inst (.i_sys_clk(clk), .i_sel(sel), .i_ready_cfg(rc), .i_wlock_cfg(wc),
    .i_loadpt_cfg(lc), .o_sel_ack(sack), .o_ready(rdy), .o_loadpt(lp), .o_wlock(wl));
  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic cmp(string n, logic [6:0] e, logic [6:0] s);
    num_checks++;
    if (s !== e)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  // Wait for request, then a one-cycle strobe
  task automatic fn(logic [5:0] c, logic [1:0] dn, logic [1:0] a);
    for (int i = 0; i < 400 && function_request_out !== 1'b1; i++) @(negedge clk);
    @(posedge clk);
    fs <= 1'b1;
    w <= {c, 2'b01, dn, 1'b0, a, 17'h0};
    @(posedge clk);
    fs <= 1'b0;
  endtask
  task automatic drain();
    for (int i = 0; i < 30000 && (sq.size() + fq.size()) > 0; i++) @(posedge clk);
    // A stuck queue is a failure, not a quiet exit
    if (sq.size() + fq.size() > 0) errors++;
  endtask
  // Result watcher, also acknowledges interrupts
  always @(posedge clk)
  begin
    np <= np + {3'h0, rwd === 1'b1, 2'h0, wrst === 1'b1};
    if (stb === 1'b1 && fq.size() > 0) cmp("frame", fq.pop_front(), fd);
    if (oint === 1'b1 && iack === 1'b0 && sq.size() > 0) cmp("status", {2'h0, sq.pop_front()}, {2'h0, ind[4:0]});
    iack <= oint === 1'b1 && iack === 1'b0;
  end
  initial
  begin
    void'($urandom(32'hcf9a));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    // Rejection table: density, address, fault, lockout, load point, swap, rewind
    for (int k = 0; k < 8; k++)
    begin
      {rc, wc, lc} <= tbl[k][10:5];
      en <= (k != 0);
      sw <= (k == 6);
      sq.push_back(tbl[k][4:0]);
      fn(tbl[k][20:15], tbl[k][14:13], tbl[k][12:11]);
      if (k == 0)
      begin
        repeat (20) @(posedge clk);
        cmp("held", 7'h01, {5'h0, oint, st[1]});
        en <= 1'b1;
      end
      drain();
    end
    // Two random words, then the host goes quiet
    rc <= 2'h3;
    wc <= 2'h0;
    lc <= 2'h0;
    // Random readback parity error: no repeat request, interrupt at window end
    d = 30'($urandom());
    pe <= d[0];
    sq.push_back({4'h0, !d[0]});
    fn(6'h10, 2'h1, 2'h1);
    for (int j = 0; j < 2; j++)
    begin
      d = 30'($urandom());
      for (int i = 4; i >= 0; i--) fq.push_back({~^d[i*6+:6], d[i*6+:6]});
      for (int i = 0; i < 400 && oreq !== 1'b1; i++) @(negedge clk);
      if (j == 0) cmp("start", 7'h71, {fwd, wrt, rd, wrst, dns});
      @(posedge clk);
      ack <= 1'b1;
      w <= d;
      @(posedge clk);
      ack <= 1'b0;
    end
    drain();
    repeat (40) @(posedge clk);
    cmp("pulses", 7'h09, np);
    cmp("idle", 7'h01, {3'h0, fwd, wrt, rd, function_request_out});
    end_sim();
  end
  initial
  begin
    #2000000;
    errors++;
    end_sim();
  end
endmodule
`default_nettype wire
